// file: src/nvm_prog_port.sv
/*
 * Parallel and serial external programming logic with its own memory arrays.
 * Assumes host pins are asynchronous; they are synchronised before use.
 */
`timescale 1ns/1ps
module nvm_prog_port #(
    parameter int FLASH_WORDS = 8192,
    parameter int EE_BYTES = 256,
    parameter int FLASH_WAIT = nvm_prog_pkg::FLASH_WAIT_CYC,
    parameter int EEPROM_WAIT = nvm_prog_pkg::EEPROM_WAIT_CYC,
    parameter int ERASE_WAIT = nvm_prog_pkg::ERASE_WAIT_CYC,
    parameter logic [7:0] SIG0 = 8'h11,
    parameter logic [7:0] SIG1 = 8'h22,
    parameter logic [7:0] SIG2 = 8'h33,
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ext_clock_in_i,
    input wire logic action_sel_hi_i,
    input wire logic action_sel_lo_i,
    input wire logic byte_sel_one_i,
    input wire logic byte_sel_two_i,
    input wire logic page_latch_strobe_i,
    input wire logic store_n_i,
    input wire logic read_drive_n_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    output logic op_done_flag_o,
    input wire logic serial_sel_i,
    input wire logic sck_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic [7:0] fuse_low_o,
    output logic [7:0] lock_bits_o
);
    import nvm_prog_pkg::*;
    // sig0..2 and cal_byte defaults are arbitrary

    localparam int FA = $clog2(FLASH_WORDS);
    localparam int EA = $clog2(EE_BYTES);
    localparam int PG = 64;
    localparam int PA = 6;

    logic [15:0] flash_mem [FLASH_WORDS];
    logic [7:0] ee_mem [EE_BYTES];
    logic [15:0] fpage [PG];
    logic [7:0] epage [PG];
    logic [PG-1:0] eload_reg;

    ////////////////////////////////////////////////////////////////
    nvm_sync_if sp ();
    // active-low strobes enter inverted: the cleared sync flops then match their idle
    // level, so no false store edge or bus drive follows reset
    assign sp.raw = {serial_sel_i, sck_i, mosi_i, ext_clock_in_i, page_latch_strobe_i,
                     ~store_n_i, ~read_drive_n_i, byte_sel_one_i, byte_sel_two_i, 1'b0};
    nvm_pin_sync #(.WIDTH(10)) u_sync (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .pins(sp)
    );
    wire ser_mode = sp.level[9];
    wire sck_rise = sp.rise[8];
    wire sck_fall = sp.fall[8];
    wire mosi_s = sp.level[7];
    wire load_pulse = sp.rise[6] & ~ser_mode;
    wire latch_pulse = sp.rise[5] & ~ser_mode;
    wire store_pulse = sp.rise[4] & ~ser_mode;
    wire rd_on = sp.level[3];
    wire bs1 = sp.level[2];
    wire bs2 = sp.level[1];
    // data and action pins are held stable around the load strobe, so they are
    // sampled with two flops too and read only at the synchronised edge
    logic [9:0] pd_meta_reg;
    logic [9:0] pd_reg;
    always_ff @(posedge clk_sys_i) begin
        pd_meta_reg <= {action_sel_hi_i, action_sel_lo_i, data_i};
        pd_reg <= pd_meta_reg;
    end
    wire [1:0] act = pd_reg[9:8];
    wire [7:0] pdat = pd_reg[7:0];

    ////////////////////////////////////////////////////////////////
    logic [7:0] cmd_reg, addr_lo_reg, addr_hi_reg, dat_lo_reg, dat_hi_reg;
    logic [7:0] fuse_lo_reg, fuse_hi_reg, fuse_ext_reg, lock_reg;
    logic [23:0] busy_cnt_reg;
    op_kind_t op_reg;
    logic [7:0] op_dat_reg;
    logic [15:0] op_addr_reg;
    logic [1:0] fuse_tgt_reg;

    wire busy = (op_reg != OP_NONE);
    wire lock_frozen = (lock_reg & LOCK_BOTH_MASK) == 8'h00;
    wire [15:0] paddr = {addr_hi_reg, addr_lo_reg};

    // serial shift engine
    logic [31:0] sh_reg;
    logic [7:0] tx_reg;
    logic [4:0] bit_cnt_reg;
    logic ser_en_reg;
    // at the last rising edge of a frame the shifter holds 31 bits, byte 4 minus its lsb
    wire [7:0] sb1 = sh_reg[30:23];
    wire [7:0] sb2 = sh_reg[22:15];
    wire [7:0] sb3 = sh_reg[14:7];
    wire byte_end = sck_rise & (bit_cnt_reg[2:0] == 3'h7);
    wire instr_end = sck_rise & (bit_cnt_reg == 5'h1F);
    wire [7:0] sb4 = {sh_reg[6:0], mosi_s};

    // read answer picked at the end of byte 3 (23 bits held), shown during byte 4
    logic [7:0] ans3;
    wire [7:0] a1 = sh_reg[22:15];
    wire [7:0] a2 = sh_reg[14:7];
    wire [7:0] a3 = {sh_reg[6:0], mosi_s};
    always_comb begin
        ans3 = 8'h00;
        case (a1)
            SI_POLL: ans3 = {7'h00, busy};
            SI_RD_HI: ans3 = flash_mem[FA'({a2, a3})][15:8];
            SI_RD_LO: ans3 = flash_mem[FA'({a2, a3})][7:0];
            SI_RD_EE: ans3 = ee_mem[EA'({a2, a3})];
            SI_RD_LOCK: ans3 = (a2 == SI_HI_SEL) ? fuse_hi_reg : lock_reg;
            SI_RD_FUSE: ans3 = (a2 == SI_HI_SEL) ? fuse_ext_reg : fuse_lo_reg;
            SI_RD_SIG: ans3 = (a3 == 8'h00) ? SIG0 : (a3 == 8'h01) ? SIG1 : SIG2;
            SI_RD_CAL: ans3 = CAL_BYTE;
            default: ans3 = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i || !ser_mode) begin
            sh_reg <= '0;
            tx_reg <= 8'h00;
            bit_cnt_reg <= 5'h00;
            miso_o <= 1'b0;
        end else begin
            if (sck_rise) begin
                sh_reg <= {sh_reg[30:0], mosi_s};
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
                if (bit_cnt_reg == 5'h0F) begin
                    tx_reg <= {sh_reg[6:0], mosi_s};
                end else if (bit_cnt_reg == 5'h17) begin
                    tx_reg <= ans3;
                end else if (byte_end) begin
                    tx_reg <= 8'h00;
                end else begin
                    tx_reg <= {tx_reg[6:0], 1'b0};
                end
            end
            if (sck_fall) begin
                miso_o <= tx_reg[7];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cmd_reg <= 8'h00;
            addr_lo_reg <= 8'h00;
            addr_hi_reg <= 8'h00;
            dat_lo_reg <= ERASED;
            dat_hi_reg <= ERASED;
            fuse_lo_reg <= ERASED;
            fuse_hi_reg <= ERASED;
            fuse_ext_reg <= ERASED;
            lock_reg <= ERASED;
            busy_cnt_reg <= '0;
            op_reg <= OP_NONE;
            op_dat_reg <= 8'h00;
            op_addr_reg <= 16'h0000;
            fuse_tgt_reg <= 2'h0;
            ser_en_reg <= 1'b0;
            eload_reg <= '0;
        end else begin
            if (!ser_mode) begin
                ser_en_reg <= 1'b0;
            end
            if (load_pulse) begin
                case (act)
                    ACT_ADDR: if (bs1) addr_hi_reg <= pdat; else addr_lo_reg <= pdat;
                    ACT_DATA: if (bs1) dat_hi_reg <= pdat; else dat_lo_reg <= pdat;
                    ACT_CMD: cmd_reg <= pdat;
                    default: ;
                endcase
            end
            if (latch_pulse && cmd_reg == CMD_WR_EE) begin
                epage[addr_lo_reg[PA-1:0]] <= dat_lo_reg;
                eload_reg[addr_lo_reg[PA-1:0]] <= 1'b1;
            end
            if (latch_pulse && cmd_reg == CMD_WR_FLASH) begin
                fpage[addr_lo_reg[PA-1:0]] <= {dat_hi_reg, dat_lo_reg};
            end
            if (store_pulse && !busy) begin
                op_addr_reg <= paddr;
                op_dat_reg <= dat_lo_reg;
                case (cmd_reg)
                    CMD_WR_EE: if (!bs1) begin
                        op_reg <= OP_EEPG;
                        busy_cnt_reg <= 24'(EEPROM_WAIT);
                    end
                    CMD_WR_FLASH: begin
                        op_reg <= OP_FLASH;
                        busy_cnt_reg <= 24'(FLASH_WAIT);
                    end
                    CMD_ERASE: begin
                        op_reg <= OP_ERASE;
                        busy_cnt_reg <= 24'(ERASE_WAIT);
                    end
                    CMD_WR_FUSE: begin
                        op_reg <= OP_FUSE;
                        fuse_tgt_reg <= {bs2, bs1};
                        busy_cnt_reg <= 24'(EEPROM_WAIT);
                    end
                    CMD_WR_LOCK: if (!lock_frozen) begin
                        op_reg <= OP_LOCK;
                        busy_cnt_reg <= 24'(EEPROM_WAIT);
                    end
                    default: ;
                endcase
            end
            if (instr_end) begin
                if (sb1 == SI_ENABLE && sb2 == SI_EN2) begin
                    ser_en_reg <= 1'b1;
                end else if (ser_en_reg && !busy) begin
                    op_addr_reg <= {sb2, sb3};
                    op_dat_reg <= sb4;
                    case (sb1)
                        SI_ENABLE: begin
                            if (sb2 == SI_ERASE2) begin
                                op_reg <= OP_ERASE;
                                busy_cnt_reg <= 24'(ERASE_WAIT);
                            end else if (sb2 == SI_LOCK2 && !lock_frozen) begin
                                op_reg <= OP_LOCK;
                                busy_cnt_reg <= 24'(EEPROM_WAIT);
                            end else if (sb2 == SI_FUSE2 || sb2 == SI_FUSEH2 ||
                                         sb2 == SI_FUSEX2) begin
                                op_reg <= OP_FUSE;
                                fuse_tgt_reg <= (sb2 == SI_FUSEH2) ? 2'h1 :
                                                (sb2 == SI_FUSEX2) ? 2'h2 : 2'h0;
                                busy_cnt_reg <= 24'(EEPROM_WAIT);
                            end
                        end
                        SI_LD_LO: fpage[sb3[PA-1:0]][7:0] <= sb4;
                        SI_LD_HI: fpage[sb3[PA-1:0]][15:8] <= sb4;
                        SI_LD_EE: begin
                            epage[sb3[PA-1:0]] <= sb4;
                            eload_reg[sb3[PA-1:0]] <= 1'b1;
                        end
                        SI_WR_PAGE: begin
                            op_reg <= OP_FLASH;
                            busy_cnt_reg <= 24'(FLASH_WAIT);
                        end
                        SI_WR_EE: begin
                            op_reg <= OP_EE;
                            busy_cnt_reg <= 24'(EEPROM_WAIT);
                        end
                        SI_WR_EEPG: begin
                            op_reg <= OP_EEPG;
                            busy_cnt_reg <= 24'(EEPROM_WAIT);
                        end
                        default: ;
                    endcase
                end
            end
            if (busy) begin
                if (busy_cnt_reg > 24'h1) begin
                    busy_cnt_reg <= busy_cnt_reg - 24'h1;
                end else begin
                    op_reg <= OP_NONE;
                    case (op_reg)
                        OP_EE: ee_mem[EA'(op_addr_reg)] <= op_dat_reg;
                        OP_EEPG: begin
                            for (int i = 0; i < PG; i++) begin
                                if (eload_reg[i]) begin
                                    ee_mem[EA'({op_addr_reg[EA-1:PA], PA'(i)})] <= epage[i];
                                end
                            end
                            eload_reg <= '0;
                        end
                        OP_FLASH: begin
                            for (int i = 0; i < PG; i++) begin
                                flash_mem[FA'({op_addr_reg[FA-1:PA], PA'(i)})] <= fpage[i];
                            end
                        end
                        OP_ERASE: begin
                            for (int i = 0; i < FLASH_WORDS; i++) begin
                                flash_mem[i] <= {ERASED, ERASED};
                            end
                            for (int i = 0; i < EE_BYTES; i++) begin
                                ee_mem[i] <= ERASED;
                            end
                            lock_reg <= ERASED;
                        end
                        OP_FUSE: case (fuse_tgt_reg)
                            2'h1: fuse_hi_reg <= op_dat_reg;
                            2'h2: fuse_ext_reg <= op_dat_reg;
                            default: fuse_lo_reg <= op_dat_reg;
                        endcase
                        OP_LOCK: lock_reg <= lock_reg & op_dat_reg;
                        default: ;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    logic [7:0] rd_sel;
    always_comb begin
        rd_sel = 8'h00;
        case (cmd_reg)
            CMD_RD_FLASH: rd_sel = bs1 ? flash_mem[FA'(paddr)][15:8] :
                                         flash_mem[FA'(paddr)][7:0];
            CMD_RD_EE: rd_sel = ee_mem[EA'(paddr)];
            CMD_RD_FUSE: case ({bs2, bs1})
                2'h0: rd_sel = fuse_lo_reg;
                2'h3: rd_sel = fuse_hi_reg;
                2'h2: rd_sel = fuse_ext_reg;
                default: rd_sel = lock_reg;
            endcase
            CMD_RD_SIG: begin
                if (bs1) begin
                    rd_sel = (addr_lo_reg == CAL_ADDR) ? CAL_BYTE : 8'h00;
                end else begin
                    rd_sel = (addr_lo_reg == 8'h00) ? SIG0 : (addr_lo_reg == 8'h01) ? SIG1 :
                             (addr_lo_reg == SIG_LAST) ? SIG2 : 8'h00;
                end
            end
            default: rd_sel = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            data_o <= 8'h00;
            data_oe_o <= 1'b0;
        end else begin
            data_o <= rd_sel;
            data_oe_o <= rd_on & ~ser_mode;
        end
    end

    assign op_done_flag_o = ~busy;
    assign fuse_low_o = fuse_lo_reg;
    assign lock_bits_o = lock_reg;
endmodule : nvm_prog_port

// file: src/nvm_prog_pkg.sv
/*
 * Constants, command codes and timing for the external programming port.
 * Assumes a 125 MHz system clock and host-driven pins that are asynchronous to it.
 */
package nvm_prog_pkg;
    localparam int CLK_MHZ = 125;
    localparam int FLASH_WAIT_US = 4500;
    localparam int EEPROM_WAIT_US = 3600;
    localparam int ERASE_WAIT_US = 9000;
    localparam int FLASH_WAIT_CYC = FLASH_WAIT_US * CLK_MHZ;
    localparam int EEPROM_WAIT_CYC = EEPROM_WAIT_US * CLK_MHZ;
    localparam int ERASE_WAIT_CYC = ERASE_WAIT_US * CLK_MHZ;

    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;

    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EE = 8'h11;
    localparam logic [7:0] CMD_RD_SIG = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EE = 8'h03;

    localparam logic [7:0] SI_ENABLE = 8'hAC;
    localparam logic [7:0] SI_EN2 = 8'h53;
    localparam logic [7:0] SI_ERASE2 = 8'h80;
    localparam logic [7:0] SI_LOCK2 = 8'hE0;
    localparam logic [7:0] SI_FUSE2 = 8'hA0;
    localparam logic [7:0] SI_FUSEH2 = 8'hA8;
    localparam logic [7:0] SI_FUSEX2 = 8'hA4;
    localparam logic [7:0] SI_POLL = 8'hF0;
    localparam logic [7:0] SI_LD_HI = 8'h48;
    localparam logic [7:0] SI_LD_LO = 8'h40;
    localparam logic [7:0] SI_LD_EE = 8'hC1;
    localparam logic [7:0] SI_RD_HI = 8'h28;
    localparam logic [7:0] SI_RD_LO = 8'h20;
    localparam logic [7:0] SI_RD_EE = 8'hA0;
    localparam logic [7:0] SI_RD_LOCK = 8'h58;
    localparam logic [7:0] SI_RD_SIG = 8'h30;
    localparam logic [7:0] SI_RD_FUSE = 8'h50;
    localparam logic [7:0] SI_RD_CAL = 8'h38;
    localparam logic [7:0] SI_HI_SEL = 8'h08;
    localparam logic [7:0] SI_WR_PAGE = 8'h4C;
    localparam logic [7:0] SI_WR_EE = 8'hC0;
    localparam logic [7:0] SI_WR_EEPG = 8'hC2;

    localparam logic [7:0] ERASED = 8'hFF;
    localparam logic [7:0] LOCK_BOTH_MASK = 8'h03;
    localparam logic [7:0] SIG_LAST = 8'h02;
    localparam logic [7:0] CAL_ADDR = 8'h00;

    typedef enum logic [2:0] {
        OP_NONE, OP_FLASH, OP_EE, OP_EEPG, OP_ERASE, OP_FUSE, OP_LOCK
    } op_kind_t;
endpackage : nvm_prog_pkg

// file: src/nvm_sync_if.sv
/*
 * Carrier for the synchronised host pins between the top and the edge stage.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ps
interface nvm_sync_if;
    logic [9:0] raw;
    logic [9:0] level;
    logic [9:0] rise;
    logic [9:0] fall;
    modport stage (input raw, output level, rise, fall);
    modport user (output raw, input level, rise, fall);
endinterface : nvm_sync_if

// file: src/nvm_pin_sync.sv
/*
 * Two-flop synchroniser with edge detect for the host pins.
 * Assumes inputs asynchronous to clk_sys_i.
 */
`timescale 1ns/1ps
module nvm_pin_sync #(
    parameter int WIDTH = 10
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    nvm_sync_if.stage pins
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] last_reg;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
        end else begin
            meta_reg <= pins.raw;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign pins.level = sync_reg;
    assign pins.rise = sync_reg & ~last_reg;
    assign pins.fall = ~sync_reg & last_reg;
endmodule : nvm_pin_sync

// file: testbench/nvm_prog_port_monitor.sv
/* Checker for the programming port, bound to its top module.
   Assumes it sees only top-level ports; all waits set alike. */
`timescale 1ns/1ps
module nvm_prog_port_monitor #(
    parameter int ERASE_WAIT = 20
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic store_n_i,
    input wire logic read_drive_n_i,
    input wire logic sck_i,
    input wire logic data_oe_o,
    input wire logic op_done_flag_o,
    input wire logic miso_o,
    input wire logic [7:0] fuse_low_o,
    input wire logic [7:0] lock_bits_o
);
    logic [15:0] busy_cnt_reg;
    logic [1:0] busy_hist_reg;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // state may commit on the edge where busy ends, so keep two cycles of history
    always_ff @(posedge clk_sys_i) begin
        busy_cnt_reg <= op_done_flag_o ? 16'h0000 : busy_cnt_reg + 16'h0001;
        busy_hist_reg <= {busy_hist_reg[0], !op_done_flag_o};
    end
    ////////////////////////////////////////////////////////////////////////
    a_oe_on_read: assert property (!read_drive_n_i [*4] |-> data_oe_o)
        else $error("bus not driven during read");
    a_oe_released: assert property (read_drive_n_i [*4] |-> !data_oe_o)
        else $error("bus driven without read");
    a_busy_min_len: assert property ($fell(op_done_flag_o) |-> !op_done_flag_o [*8])
        else $error("busy too short");
    a_busy_max_len: assert property (busy_cnt_reg <= 16'(ERASE_WAIT + 8))
        else $error("busy too long");
    a_lock_frozen: assert property (lock_bits_o[1:0] == 2'h0 |=>
        (~lock_bits_o & $past(lock_bits_o)) == 8'h00)
        else $error("lock programmed while locked");
    a_lock_erase_only: assert property ((lock_bits_o & ~$past(lock_bits_o)) != 8'h00 |->
        busy_hist_reg != 2'h0 || !op_done_flag_o)
        else $error("lock cleared outside an operation");
    a_fuse_in_op: assert property ($changed(fuse_low_o) |->
        busy_hist_reg != 2'h0 || !op_done_flag_o)
        else $error("fuse changed outside an operation");
    a_miso_on_fall: assert property ($changed(miso_o) |-> !sck_i && $past(sck_i, 6))
        else $error("serial out moved off a falling edge");
    a_ready_at_start: assert property ($fell(reset_i) |-> op_done_flag_o && !data_oe_o)
        else $error("not idle after reset");
    c_store_busy: cover property ($fell(store_n_i) ##[1:8] $fell(op_done_flag_o));
    c_locked: cover property (lock_bits_o[1:0] == 2'h0);
    c_miso_move: cover property ($changed(miso_o));
endmodule : nvm_prog_port_monitor

// file: testbench/nvm_serial_host.sv
/* Serial programmer model: frames four-byte instructions on sck and mosi.
   Assumes the device samples both pins with its own faster clock. */
`timescale 1ns/1ps
module nvm_serial_host #(
    parameter int HALF_NS = 40
) (
    output logic sck_o,
    output logic mosi_o,
    input wire logic miso_i
);
    initial begin
        sck_o = 1'b0;
        mosi_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // sck stands low between frames; each half spans five system clocks
    task automatic xfer(input logic [31:0] ins, output logic [31:0] rx);
        #3;
        for (int i = 31; i >= 0; i--) begin
            mosi_o = ins[i];
            #(HALF_NS);
            sck_o = 1'b1;
            rx[i] = miso_i;
            #(HALF_NS);
            sck_o = 1'b0;
        end
        mosi_o = ~ins[0];
        #(HALF_NS);
    endtask : xfer
endmodule : nvm_serial_host

// file: testbench/tb.sv
/* Self-checking bench: parallel and serial programming sessions.
   Assumes short wait parameters and the serial host model. */
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end
module tb;
    import nvm_prog_pkg::*;
    localparam int WAIT = 20; // waits scaled down to fit the run
    localparam logic [7:0] SIG [3] = '{8'h5A, 8'hC3, 8'h96}; // arbitrary values
    localparam logic [7:0] CAL = 8'hA5;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic xclk = 1'b0, sel1 = 1'b0, sel2 = 1'b0, pgl = 1'b0, store_n = 1'b1;
    logic rd_n = 1'b1, ser = 1'b0, doe, done, sck, mosi, miso;
    logic [1:0] act = 2'h3;
    logic [7:0] din = 8'h00, dout, fuse, lock;
    logic [31:0] rx, seed = 32'hE334A758;
    int mismatches = 0;
    int check_count = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    nvm_prog_port #(.FLASH_WAIT(WAIT), .EEPROM_WAIT(WAIT), .ERASE_WAIT(WAIT), .SIG0(SIG[0]),
        .SIG1(SIG[1]), .SIG2(SIG[2]), .CAL_BYTE(CAL)) DUT (.clk_sys_i(clk_sys_i),
        .reset_i(reset_i), .ext_clock_in_i(xclk), .action_sel_hi_i(act[1]),
        .action_sel_lo_i(act[0]), .byte_sel_one_i(sel1), .byte_sel_two_i(sel2),
        .page_latch_strobe_i(pgl), .store_n_i(store_n), .read_drive_n_i(rd_n), .data_i(din),
        .data_o(dout), .data_oe_o(doe), .op_done_flag_o(done), .serial_sel_i(ser),
        .sck_i(sck), .mosi_i(mosi), .miso_o(miso), .fuse_low_o(fuse), .lock_bits_o(lock));
    nvm_serial_host host (.sck_o(sck), .mosi_o(mosi), .miso_i(miso));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    function automatic logic [7:0] lockexp(logic [7:0] old, logic [7:0] wr);
        return (old[1:0] == 2'h0) ? old : (old & wr);
    endfunction : lockexp
    task automatic tick(int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : tick
    task automatic ld(logic [1:0] a, logic [7:0] d, logic s1 = 1'b0);
        act <= a;
        sel1 <= s1;
        din <= d;
        tick(1);
        xclk <= 1'b1;
        tick(4);
        xclk <= 1'b0;
        tick(4);
    endtask : ld
    task automatic store(bit chk);
        store_n <= 1'b0;
        tick(4);
        store_n <= 1'b1;
        tick(3);
        if (chk) `CHK(done, 1'b0)
        for (int i = 0; i < 200 && done !== 1'b1; i++) tick(1);
        `CHK(done, 1'b1)
    endtask : store
    task automatic rd(logic s2, logic s1, logic [7:0] exp);
        sel2 <= s2;
        sel1 <= s1;
        rd_n <= 1'b0;
        tick(6);
        `CHK(dout, exp)
        `CHK(doe, 1'b1)
        rd_n <= 1'b1;
        sel2 <= 1'b0;
        tick(4);
    endtask : rd
    task automatic sx(logic [31:0] ins);
        host.xfer(ins, rx);
        tick(2);
    endtask : sx
    task automatic tally_and_finish();
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #400us;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] a, d, w;
        tick(20);
        reset_i <= 1'b0;
        tick(4);
        `CHK(fuse, ERASED)
        `CHK(lock, ERASED)
        for (int i = 0; i < 3; i++) begin
            a = rnd();
            d = rnd();
            ld(ACT_CMD, CMD_WR_EE);
            ld(ACT_ADDR, 8'h00, 1'b1);
            ld(ACT_ADDR, a);
            ld(ACT_DATA, d);
            pgl <= 1'b1;
            tick(4);
            pgl <= 1'b0;
            tick(4);
            store(1'b1);
            ld(ACT_CMD, CMD_RD_EE);
            ld(ACT_ADDR, 8'h00, 1'b1);
            ld(ACT_ADDR, a);
            rd(1'b0, 1'b0, d);
        end
        for (int t = 0; t < 3; t++) begin
            d = rnd();
            ld(ACT_CMD, CMD_WR_FUSE);
            ld(ACT_DATA, d);
            sel1 <= (t == 1);
            sel2 <= (t == 2);
            tick(2);
            store(1'b1);
            ld(ACT_CMD, CMD_RD_FUSE);
            rd(t != 0, t == 1, d);
            if (t == 0) `CHK(fuse, d)
        end
        w = rnd() & 8'hFC;
        ld(ACT_CMD, CMD_WR_LOCK);
        ld(ACT_DATA, w);
        store(1'b1);
        ld(ACT_CMD, CMD_RD_FUSE);
        rd(1'b0, 1'b1, lockexp(ERASED, w));
        d = rnd();
        ld(ACT_CMD, CMD_WR_LOCK);
        ld(ACT_DATA, d);
        store(1'b0);
        `CHK(lock, lockexp(w, d))
        ld(ACT_CMD, CMD_RD_SIG);
        for (int i = 0; i < 3; i++) begin
            ld(ACT_ADDR, 8'(i));
            rd(1'b0, 1'b0, SIG[i]);
        end
        ld(ACT_ADDR, CAL_ADDR);
        rd(1'b0, 1'b1, CAL);
        ld(ACT_CMD, CMD_ERASE);
        store(1'b1);
        `CHK(lock, ERASED)
        ld(ACT_CMD, CMD_RD_FLASH);
        ld(ACT_ADDR, rnd() & 8'h1F, 1'b1);
        ld(ACT_ADDR, rnd());
        rd(1'b0, 1'b0, ERASED);
        rd(1'b0, 1'b1, ERASED);
        ser <= 1'b1;
        tick(4); // enable wait shortened to fit the run
        a = rnd();
        sx({SI_WR_EE, 8'h00, a, rnd()}); // refused: not yet enabled
        sx({SI_ENABLE, SI_EN2, 16'h0000});
        `CHK(rx[15:8], SI_EN2)
        sx({SI_RD_EE, 8'h00, a, 8'h00});
        `CHK(rx[7:0], ERASED)
        for (int j = 0; j < 2; j++) begin
            d = rnd();
            sx({SI_WR_EE, 8'h00, a, d});
            `CHK(done, 1'b0)
            for (int k = 0; k < 20; k++) begin
                sx({SI_POLL, 24'h0});
                if (rx[0] === 1'b0) break;
            end
            `CHK(rx[0], 1'b0)
            sx({SI_RD_EE, 8'h00, a, 8'h00});
            `CHK(rx[7:0], d)
        end
        w = rnd();
        sx({SI_LD_LO, 8'h00, 8'h05, d});
        sx({SI_LD_HI, 8'h00, 8'h05, w});
        sx({SI_WR_PAGE, 8'h01, 8'h00, 8'h00});
        tick(40);
        sx({SI_RD_LO, 8'h01, 8'h05, 8'h00});
        `CHK(rx[7:0], d)
        sx({SI_RD_HI, 8'h01, 8'h05, 8'h00});
        `CHK(rx[7:0], w)
        sx({SI_RD_SIG, 8'h00, 8'h01, 8'h00});
        `CHK(rx[7:0], SIG[1])
        tally_and_finish();
    end
endmodule : tb
bind nvm_prog_port nvm_prog_port_monitor #(.ERASE_WAIT(ERASE_WAIT)) mon (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .store_n_i(store_n_i),
    .read_drive_n_i(read_drive_n_i), .sck_i(sck_i), .data_oe_o(data_oe_o),
    .op_done_flag_o(op_done_flag_o), .miso_o(miso_o), .fuse_low_o(fuse_low_o),
    .lock_bits_o(lock_bits_o));
